// ---- common/tcb_pkg.sv ----
package tcb_pkg;

    // channel and buffer counts
    localparam int NUM_CH  = 5;
    localparam int NUM_BUF = 4;

    // register byte addresses on the internal 16-bit bus
    localparam logic [4:0] CTRL_CH0_ADDR  = 5'h00;
    localparam logic [4:0] CTRL_CH4_ADDR  = 5'h08;
    localparam logic [4:0] BUF_A_CH3_ADDR = 5'h10;
    localparam logic [4:0] BUF_B_CH4_ADDR = 5'h16;

    // reset values
    localparam logic [7:0]  CTRL_RESET = 8'h80;
    localparam logic [15:0] BUF_RESET  = 16'hFFFF;

    // counter control field positions
    localparam int CTRL_FIXED_BIT = 7;
    localparam int CLR_SEL_LSB    = 5;
    localparam int EDGE_SEL_LSB   = 3;
    localparam int PRESCALE_LSB   = 0;

    // clear select codes
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A    = 2'h1;
    localparam logic [1:0] CLR_B    = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;

    // edge select codes, upper bit set means both edges
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // prescaler divider width, system clock period
    localparam int DIV_W      = 3;
    localparam int CLK_PERIOD_NS = 10;

    // channel index that supports phase counting
    localparam int PHASE_CH = 2;

endpackage

// ---- verif/tcb_timer_clock_clear_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
// port-level checks; standby is excluded where it overrides the cause
module tcb_timer_clock_clear_properties
    import tcb_pkg::*;
(
    input wire logic [0:0]         clk_i,
    input wire logic               arst_n_i,
    input wire logic               standby_i,
    input wire logic [4:0]         bus_addr_i,
    input wire logic               bus_wr_i,
    input wire logic               bus_rd_i,
    input wire logic [1:0]         bus_be_i,
    input wire logic [15:0]        bus_wdata_i,
    input wire logic [15:0]        bus_rdata_o,
    input wire logic [NUM_CH-1:0]  match_a_i,
    input wire logic [NUM_CH-1:0]  match_b_i,
    input wire logic [NUM_CH-1:0]  capture_a_i,
    input wire logic [NUM_CH-1:0]  capture_b_i,
    input wire logic [NUM_CH-1:0]  capture_mode_a_i,
    input wire logic [NUM_CH-1:0]  capture_mode_b_i,
    input wire logic               phase_count_enable_i,
    input wire logic               phase_tick_i,
    input wire logic               buf_en_a_ch3_i,
    input wire logic               buf_en_b_ch4_i,
    input wire logic [15:0]        general_reg_b_ch4_i,
    input wire logic [NUM_CH-1:0]  count_tick_o,
    input wire logic [NUM_CH-1:0]  count_clear_o,
    input wire logic [NUM_BUF-1:0] gr_load_o,
    input wire logic [15:0]        buffer_a_ch3_o,
    input wire logic [15:0]        buffer_b_ch4_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // causes of a buffer transfer or a full-word buffer write
    sequence s_match_a3;
        buf_en_a_ch3_i && !capture_mode_a_i[3] && match_a_i[3] && !standby_i;
    endsequence
    sequence s_capt_b4;
        buf_en_b_ch4_i && capture_mode_b_i[4] && capture_b_i[4] && !standby_i;
    endsequence
    sequence s_word_wr_a3;
        bus_wr_i && bus_addr_i == BUF_A_CH3_ADDR && bus_be_i == 2'h3 && !capture_a_i[3] && !standby_i;
    endsequence

    cmp_reload_a: assert property (s_match_a3 |=> gr_load_o[0])
        else $error("no reload after match");
    no_reload_a: assert property (!buf_en_a_ch3_i || capture_mode_a_i[3] |=> !gr_load_o[0])
        else $error("reload without compare buffering");
    capt_move_a: assert property (s_capt_b4 |=> buffer_b_ch4_o == $past(general_reg_b_ch4_i))
        else $error("capture did not move old value");
    word_write_a: assert property (s_word_wr_a3 |=> buffer_a_ch3_o == $past(bus_wdata_i))
        else $error("buffer word write lost");
    standby_init_a: assert property (standby_i |=> buffer_b_ch4_o == BUF_RESET && gr_load_o == 4'h0)
        else $error("standby did not initialise");
    clear_cause_a: assert property (count_clear_o[0]
        |-> $past(|{match_a_i, match_b_i, capture_a_i, capture_b_i}))
        else $error("clear without event");
    phase_ovr_a: assert property (phase_count_enable_i && !phase_tick_i && !standby_i
        |=> !count_tick_o[PHASE_CH])
        else $error("tick while phase counting idle");
    ctrl_read_a: assert property (bus_rd_i && !standby_i && bus_addr_i <= CTRL_CH4_ADDR && !bus_addr_i[0]
        |=> bus_rdata_o[15:7] == 9'h001)
        else $error("control top bit not one");
    rdata_hold_a: assert property (!bus_rd_i && !standby_i |=> $stable(bus_rdata_o))
        else $error("read data moved without read");
endmodule

bind tcb_timer_clock_clear tcb_timer_clock_clear_properties u_props (.clk_i, .arst_n_i, .standby_i, .bus_addr_i,
    .bus_wr_i, .bus_rd_i, .bus_be_i, .bus_wdata_i, .bus_rdata_o, .match_a_i, .match_b_i, .capture_a_i, .capture_b_i,
    .capture_mode_a_i, .capture_mode_b_i, .phase_count_enable_i, .phase_tick_i, .buf_en_a_ch3_i, .buf_en_b_ch4_i,
    .general_reg_b_ch4_i, .count_tick_o, .count_clear_o, .gr_load_o, .buffer_a_ch3_o, .buffer_b_ch4_o);
`default_nettype wire

// ---- verif/test_tcb_timer_clock_clear.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_tcb_timer_clock_clear import tcb_pkg::*;;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, standby_i = 1'b0, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
    logic        phase_count_enable_i = 1'b0, phase_tick_i = 1'b0, buf_en_a_ch3_i = 1'b0, buf_en_b_ch4_i = 1'b0;
    logic        buf_en_b_ch3_i = 1'b0, buf_en_a_ch4_i = 1'b0;
    logic [4:0]  bus_addr_i = 5'h00, capture_mode_a_i = 5'h00, capture_mode_b_i = 5'h00, sync_select_i = 5'h00;
    logic [4:0]  ev [4] = '{default: 5'h00};
    logic [4:0]  count_tick_o, count_clear_o, clr_s;
    logic [3:0]  ext_clk_i = 4'h0, gr_load_o, ld_s;
    logic [1:0]  bus_be_i = 2'h0;
    logic [15:0] bus_wdata_i = 16'h0000, gr_v = 16'h0000;
    logic [15:0] bus_rdata_o, buffer_a_ch3_o, buffer_b_ch3_o, buffer_a_ch4_o, buffer_b_ch4_o;
    int          n_fail = 0, n_tests = 0, cycles = 0, timer_count;

    // event vector index: 0 match a, 1 match b, 2 capture a, 3 capture b
    tcb_timer_clock_clear dut (.clk_i, .arst_n_i, .standby_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_be_i,
        .bus_wdata_i, .bus_rdata_o, .ext_clk_i, .match_a_i(ev[0]), .match_b_i(ev[1]), .capture_a_i(ev[2]),
        .capture_b_i(ev[3]), .capture_mode_a_i, .capture_mode_b_i, .sync_select_i, .phase_count_enable_i,
        .phase_tick_i, .buf_en_a_ch3_i, .buf_en_b_ch3_i, .buf_en_a_ch4_i, .buf_en_b_ch4_i,
        .general_reg_a_ch3_i(gr_v), .general_reg_b_ch3_i(gr_v), .general_reg_a_ch4_i(gr_v),
        .general_reg_b_ch4_i(gr_v), .count_tick_o, .count_clear_o, .gr_load_o, .buffer_a_ch3_o,
        .buffer_b_ch3_o, .buffer_a_ch4_o, .buffer_b_ch4_o);

    // clock and hang guard; the run needs well under a thousand cycles
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up;
        end
    end

    // inputs move one ns after the edge so sampling never races
    task automatic cyc;
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // idle cycle after each strobe so it is never raised twice in one step
    task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
        bus_addr_i = a;
        bus_be_i = be;
        bus_wdata_i = d;
        bus_wr_i = 1'b1;
        cyc;
        bus_wr_i = 1'b0;
        cyc;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        bus_addr_i = a;
        bus_rd_i = 1'b1;
        cyc;
        bus_rd_i = 1'b0;
        cyc;
        chk(bus_rdata_o, exp);
    endtask
    // one-cycle event; the one-cycle pulses are sampled right after it is taken
    task automatic fire(input int k, input int ch);
        ev[k][ch] = 1'b1;
        cyc;
        ev[k][ch] = 1'b0;
        clr_s = count_clear_o;
        ld_s = gr_load_o;
        cyc;
    endtask
    task automatic ticks(input int ch, input int n);
        timer_count = 0;
        repeat (n) begin
            cyc;
            timer_count += count_tick_o[ch];
        end
    endtask
    task automatic resets;
        for (int i = 0; i < NUM_CH; i++)
            rd(5'(2 * i), 16'h0080);
        for (int i = 0; i < NUM_BUF; i++)
            rd(5'(BUF_A_CH3_ADDR + 2 * i), BUF_RESET);
        // the buffer outputs feed the general registers, so look at the b ch3 and a ch4 outputs directly too
        chk(buffer_b_ch3_o, BUF_RESET);
        chk(buffer_a_ch4_o, BUF_RESET);
    endtask
    task wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        resets;
        rd(5'h01, 16'h0000);
        wr(CTRL_CH0_ADDR, 2'h1, 16'h0000);
        rd(CTRL_CH0_ADDR, 16'h0080);
        wr(BUF_A_CH3_ADDR, 2'h3, 16'h1234);
        wr(BUF_A_CH3_ADDR, 2'h1, 16'hFFAB);
        wr(BUF_A_CH3_ADDR, 2'h2, 16'hCDFF);
        rd(BUF_A_CH3_ADDR, 16'hCDAB);
        wr(5'h11, 2'h3, 16'h0000);
        rd(BUF_A_CH3_ADDR, 16'hCDAB);
        buf_en_a_ch3_i = 1'b1;
        fire(0, 3);
        chk(16'(ld_s), 16'h0001);
        buf_en_a_ch3_i = 1'b0;
        fire(0, 3);
        chk(16'(ld_s), 16'h0000);
        buf_en_b_ch3_i = 1'b1;
        buf_en_a_ch4_i = 1'b1;
        fire(1, 3);
        chk(16'(ld_s), 16'h0002);
        fire(0, 4);
        chk(16'(ld_s), 16'h0004);
        buf_en_b_ch3_i = 1'b0;
        buf_en_a_ch4_i = 1'b0;
        buf_en_b_ch4_i = 1'b1;
        capture_mode_b_i = 5'h10;
        gr_v = 16'h5A5A;
        fire(3, 4);
        chk(buffer_b_ch4_o, 16'h5A5A);
        fire(1, 4);
        chk(16'(ld_s), 16'h0000);
        buf_en_b_ch4_i = 1'b0;
        gr_v = 16'h1111;
        fire(3, 4);
        chk(buffer_b_ch4_o, 16'h5A5A);
        for (int c = 0; c < 3; c++) begin
            wr(CTRL_CH0_ADDR, 2'h1, 16'(c << CLR_SEL_LSB));
            fire(0, 0);
            chk(16'(clr_s[0]), 16'(c == 1));
            fire(1, 0);
            chk(16'(clr_s[0]), 16'(c == 2));
        end
        capture_mode_a_i = 5'h01;
        wr(CTRL_CH0_ADDR, 2'h1, 16'h0020);
        fire(2, 0);
        chk(16'(clr_s), 16'h0001);
        fire(0, 0);
        chk(16'(clr_s), 16'h0000);
        capture_mode_a_i = 5'h00;
        wr(CTRL_CH0_ADDR, 2'h1, 16'h0060);
        wr(5'h02, 2'h1, 16'h0020);
        sync_select_i = 5'h03;
        fire(0, 1);
        chk(16'(clr_s), 16'h0003);
        sync_select_i = 5'h02;
        fire(0, 1);
        chk(16'(clr_s), 16'h0002);
        // edge field set to both must not double the internal rate
        for (int p = 0; p < 4; p++) begin
            wr(CTRL_CH0_ADDR, 2'h1, 16'(p) | 16'h0018);
            repeat (2) cyc;
            ticks(0, 16);
            chk(16'(timer_count), 16'(16 >> p));
        end
        for (int p = 0; p < 4; p++)
            for (int e = 0; e < 4; e++) begin
                wr(CTRL_CH0_ADDR, 2'h1, 16'((e << EDGE_SEL_LSB) | 4 | p));
                repeat (6) cyc;
                ext_clk_i[p] = 1'b1;
                ticks(0, 8);
                chk(16'(timer_count), 16'(e != 1));
                ext_clk_i[p] = 1'b0;
                ticks(0, 8);
                chk(16'(timer_count), 16'(e > 0));
            end
        wr(5'h04, 2'h1, 16'h0000);
        phase_count_enable_i = 1'b1;
        ticks(2, 8);
        chk(16'(timer_count), 16'h0000);
        phase_tick_i = 1'b1;
        cyc;
        phase_tick_i = 1'b0;
        chk(16'(count_tick_o[2]), 16'h0001);
        wr(BUF_B_CH4_ADDR, 2'h3, 16'h0000);
        standby_i = 1'b1;
        cyc;
        standby_i = 1'b0;
        resets;
        // asynchronous reset in mid-run must restore the same values
        wr(CTRL_CH0_ADDR, 2'h1, 16'h0077);
        wr(BUF_A_CH3_ADDR, 2'h3, 16'h0000);
        arst_n_i = 1'b0;
        cyc;
        arst_n_i = 1'b1;
        resets;
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- verilog/tcb_ext_edge.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcb_ext_edge
    import tcb_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] pin_i,
    output logic      [3:0] rise_o,
    output logic      [3:0] fall_o
);

    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [3:0] last_reg;

    // two-stage synchroniser, then a history stage for edge detection
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges seen only on synchronised levels
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;

endmodule
`default_nettype wire

// ---- verilog/tcb_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcb_prescaler
    import tcb_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       standby_i,
    output logic      [3:0] tick_o
);

    logic [DIV_W-1:0] div_reg;

    // free-running divider; standby holds it at zero so phases restart cleanly
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= '0;
        end else if (standby_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // one pulse per falling edge of each divided clock (phi, phi/2, phi/4, phi/8)
    assign tick_o[0] = 1'b1;
    assign tick_o[1] = div_reg[0];
    assign tick_o[2] = &div_reg[1:0];
    assign tick_o[3] = &div_reg;

endmodule
`default_nettype wire

// ---- verilog/tcb_timer_clock_clear.sv ----
// Overview of operation
// RULE1: four 16-bit buffers paired with general registers
// RULE2: buffer role follows paired register mode
// RULE3: compare match copies buffer into general register
// RULE4: capture moves old general value into buffer
// RULE5: four separate buffering enable bits
// RULE6: buffers accessible by word or byte
// RULE7: buffers reset and standby to all ones
// RULE8: five counter controls, initialised on reset/standby
// RULE9: control top bit reads one always
// RULE10: clear select none, A, B, synchronous
// RULE11: clear event is match or capture
// RULE12: synchronous clear follows sync-selected channels
// RULE13: edge select rising, falling, both
// RULE14: prescaler picks divided clock or pin
// RULE15: internal source counts falling edges only
// RULE16: external pin counts selected edges
// RULE17: channel 2 phase counting overrides clock
// RULE18: selected clear drives counter to zero
// RULE19: pins synchronised and edge-detected first
`timescale 1ns/1ns
`default_nettype none
module tcb_timer_clock_clear
    import tcb_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      standby_i,
    // internal 16-bit register bus
    input  wire logic [4:0]                bus_addr_i,
    input  wire logic                      bus_wr_i,
    input  wire logic                      bus_rd_i,
    input  wire logic [1:0]                bus_be_i,
    input  wire logic [15:0]               bus_wdata_i,
    output logic      [15:0]               bus_rdata_o,
    // external clock pins a..d
    input  wire logic [3:0]                ext_clk_i,
    // general register events and modes, per channel
    input  wire logic [NUM_CH-1:0]         match_a_i,
    input  wire logic [NUM_CH-1:0]         match_b_i,
    input  wire logic [NUM_CH-1:0]         capture_a_i,
    input  wire logic [NUM_CH-1:0]         capture_b_i,
    input  wire logic [NUM_CH-1:0]         capture_mode_a_i,
    input  wire logic [NUM_CH-1:0]         capture_mode_b_i,
    input  wire logic [NUM_CH-1:0]         sync_select_i,
    input  wire logic                      phase_count_enable_i,
    input  wire logic                      phase_tick_i,
    // buffering enables from the function control register
    input  wire logic                      buf_en_a_ch3_i,
    input  wire logic                      buf_en_b_ch3_i,
    input  wire logic                      buf_en_a_ch4_i,
    input  wire logic                      buf_en_b_ch4_i,
    // current general register contents, channels 3 and 4
    input  wire logic [15:0]               general_reg_a_ch3_i,
    input  wire logic [15:0]               general_reg_b_ch3_i,
    input  wire logic [15:0]               general_reg_a_ch4_i,
    input  wire logic [15:0]               general_reg_b_ch4_i,
    // counter steering
    output logic      [NUM_CH-1:0]         count_tick_o,
    output logic      [NUM_CH-1:0]         count_clear_o,
    // general register reload from buffers
    output logic      [NUM_BUF-1:0]        gr_load_o,
    output logic      [15:0]               buffer_a_ch3_o,
    output logic      [15:0]               buffer_b_ch3_o,
    output logic      [15:0]               buffer_a_ch4_o,
    output logic      [15:0]               buffer_b_ch4_o
);

    // byte-lane merge, used by the buffer register writes only
    function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0]  be);
        logic [15:0] res;
        res = old_v;
        if (be[1]) begin
            res[15:8] = new_v[15:8];
        end
        if (be[0]) begin
            res[7:0] = new_v[7:0];
        end
        return res;
    endfunction

    // count source decode for one channel
    function automatic logic pick_tick(input logic [7:0] ctrl,
                                       input logic [3:0] int_tick,
                                       input logic [3:0] rise,
                                       input logic [3:0] fall);
        logic [2:0] psc;
        logic [1:0] edg;
        logic       r;
        logic       f;
        psc = ctrl[PRESCALE_LSB +: 3];
        edg = ctrl[EDGE_SEL_LSB +: 2];
        r   = rise[psc[1:0]];
        f   = fall[psc[1:0]];
        if (!psc[2]) begin
            return int_tick[psc[1:0]];                  // [RULE14] [RULE15]
        end else if (edg[1]) begin
            return r | f;                               // [RULE13] [RULE16]
        end else if (edg == EDGE_FALL) begin
            return f;                                   // [RULE13] [RULE16]
        end else begin
            return r;                                   // [RULE13] [RULE16]
        end
    endfunction

    logic [7:0]          ctrl_reg [NUM_CH];
    logic [15:0]         buf_reg  [NUM_BUF];
    logic [3:0]          int_tick;
    logic [3:0]          pin_rise;
    logic [3:0]          pin_fall;
    logic [NUM_CH-1:0]   own_clr;
    logic [NUM_CH-1:0]   clr_next;
    logic [NUM_CH-1:0]   tick_next;
    logic                sync_src;
    logic [NUM_BUF-1:0]  buf_en;
    logic [NUM_BUF-1:0]  buf_match;
    logic [NUM_BUF-1:0]  buf_cap;
    logic [NUM_BUF-1:0]  buf_cap_mode;
    logic [15:0]         gr_val   [NUM_BUF];
    logic [15:0]         rdata_next;

    tcb_prescaler u_prescaler (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .standby_i (standby_i),
        .tick_o    (int_tick)
    );

    tcb_ext_edge u_ext_edge (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .pin_i    (ext_clk_i),                          // [RULE19]
        .rise_o   (pin_rise),
        .fall_o   (pin_fall)
    );

    // buffer slot order: a ch3, b ch3, a ch4, b ch4
    assign buf_en       = {buf_en_b_ch4_i, buf_en_a_ch4_i, buf_en_b_ch3_i, buf_en_a_ch3_i}; // [RULE5]
    assign buf_match    = {match_b_i[4], match_a_i[4], match_b_i[3], match_a_i[3]};
    assign buf_cap      = {capture_b_i[4], capture_a_i[4], capture_b_i[3], capture_a_i[3]};
    assign buf_cap_mode = {capture_mode_b_i[4], capture_mode_a_i[4],
                           capture_mode_b_i[3], capture_mode_a_i[3]};
    assign gr_val[0]    = general_reg_a_ch3_i;
    assign gr_val[1]    = general_reg_b_ch3_i;
    assign gr_val[2]    = general_reg_a_ch4_i;
    assign gr_val[3]    = general_reg_b_ch4_i;

    // counter control registers; top bit is forced so it never reads zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_reg[i] <= CTRL_RESET;              // [RULE8]
            end
        end else if (standby_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_reg[i] <= CTRL_RESET;              // [RULE8]
            end
        end else if (bus_wr_i && bus_be_i[0] && bus_addr_i <= CTRL_CH4_ADDR
                     && !bus_addr_i[0]) begin
            ctrl_reg[bus_addr_i[3:1]] <= bus_wdata_i[7:0] | CTRL_RESET; // [RULE9]
        end
    end

    // buffer registers; a hardware transfer beats a cpu write in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_BUF; i++) begin
                buf_reg[i] <= BUF_RESET;                // [RULE7]
            end
        end else if (standby_i) begin
            for (int i = 0; i < NUM_BUF; i++) begin
                buf_reg[i] <= BUF_RESET;                // [RULE7]
            end
        end else begin
            for (int i = 0; i < NUM_BUF; i++) begin
                if (buf_en[i] && buf_cap_mode[i] && buf_cap[i]) begin
                    buf_reg[i] <= gr_val[i];            // [RULE2] [RULE4]
                end else if (bus_wr_i && bus_addr_i[4] && !bus_addr_i[0]
                             && bus_addr_i[2:1] == 2'(i) && !bus_addr_i[3]) begin
                    buf_reg[i] <= merge_bytes(buf_reg[i], bus_wdata_i, bus_be_i); // [RULE6]
                end
            end
        end
    end

    // compare-buffer reload strobe, one cycle after the match
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gr_load_o <= '0;
        end else if (standby_i) begin
            gr_load_o <= '0;
        end else begin
            gr_load_o <= buf_en & ~buf_cap_mode & buf_match; // [RULE2] [RULE3]
        end
    end

    // buffer outputs mirror the stored words; paired general register takes these
    assign buffer_a_ch3_o = buf_reg[0];                 // [RULE1]
    assign buffer_b_ch3_o = buf_reg[1];
    assign buffer_a_ch4_o = buf_reg[2];
    assign buffer_b_ch4_o = buf_reg[3];

    // own clear event per channel from its selected general register
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            case (ctrl_reg[c][CLR_SEL_LSB +: 2])
                CLR_A: begin
                    own_clr[c] = capture_mode_a_i[c] ? capture_a_i[c] : match_a_i[c]; // [RULE10] [RULE11]
                end
                CLR_B: begin
                    own_clr[c] = capture_mode_b_i[c] ? capture_b_i[c] : match_b_i[c]; // [RULE10] [RULE11]
                end
                default: begin
                    own_clr[c] = 1'b0;                  // [RULE10]
                end
            endcase
        end
    end

    // synchronous clear: any synchronised channel clearing itself clears each synchronised channel set to synchronous clear
    assign sync_src = |(own_clr & sync_select_i);       // [RULE12]

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            clr_next[c] = own_clr[c]
                        | (ctrl_reg[c][CLR_SEL_LSB +: 2] == CLR_SYNC
                           && sync_select_i[c] && sync_src); // [RULE12]
            tick_next[c] = pick_tick(ctrl_reg[c], int_tick, pin_rise, pin_fall);
        end
        if (phase_count_enable_i) begin
            tick_next[PHASE_CH] = phase_tick_i;         // [RULE17]
        end
    end

    // counter steering strobes; clear pulse forces the counter to zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_tick_o  <= '0;
            count_clear_o <= '0;
        end else if (standby_i) begin
            count_tick_o  <= '0;
            count_clear_o <= '0;
        end else begin
            count_tick_o  <= tick_next;
            count_clear_o <= clr_next;                  // [RULE18]
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rdata_next = 16'h0000;
        if (bus_addr_i <= CTRL_CH4_ADDR && !bus_addr_i[0]) begin
            rdata_next = {8'h00, ctrl_reg[bus_addr_i[3:1]]}; // [RULE9]
        end else if (bus_addr_i >= BUF_A_CH3_ADDR && bus_addr_i <= BUF_B_CH4_ADDR
                     && !bus_addr_i[0]) begin
            rdata_next = buf_reg[bus_addr_i[2:1]];      // [RULE6]
        end
    end

    // read data registered, valid the cycle after the read strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_rdata_o <= 16'h0000;
        end else if (bus_rd_i) begin
            bus_rdata_o <= rdata_next;
        end
    end

endmodule
`default_nettype wire
